// ### include/trig_pkg.sv
package trig_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS    = 20000;
  localparam int unsigned HOLD_MIN_PS      = 10000;
  localparam int unsigned HOLD_MIN_CYC_RAW = (HOLD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HOLD_MIN_CYC     = (HOLD_MIN_CYC_RAW < 1) ? 1 : HOLD_MIN_CYC_RAW;
  localparam int unsigned WIDTH_MIN_PS     = 2500;
  localparam int unsigned WIDTH_MIN_CYC_RAW = (WIDTH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WIDTH_MIN_CYC    = (WIDTH_MIN_CYC_RAW < 1) ? 1 : WIDTH_MIN_CYC_RAW;
  localparam int unsigned MAX_TIME_S       = 20;
  localparam int unsigned CLK_HZ           = 50000000;
  localparam longint unsigned MAX_TIME_CYC = 64'(MAX_TIME_S) * 64'(CLK_HZ);
  localparam int unsigned MAX_EVENTS       = 1000000000;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned TW        = 30;
  localparam int unsigned EW        = 30;
  localparam int unsigned NSRC      = 5;
  localparam int unsigned SRC_W     = 3;
  localparam int unsigned SYNC_RST  = 2'b00;

  typedef logic [TW-1:0] time_t;
  typedef logic [EW-1:0] count_t;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    SLOPE_POS    = 2'b00,
    SLOPE_NEG    = 2'b01,
    SLOPE_WINDOW = 2'b10
  } slope_t;

  typedef enum logic [2:0] {
    CPL_DC   = 3'b000,
    CPL_AC   = 3'b001,
    CPL_LFR  = 3'b010,
    CPL_HFR  = 3'b011,
    CPL_HF   = 3'b100
  } coupling_t;

  typedef enum logic [2:0] {
    MODE_EDGE       = 3'b000,
    MODE_GLITCH_MAX = 3'b001,
    MODE_GLITCH_MIN = 3'b010,
    MODE_EXCL_IN    = 3'b011,
    MODE_EXCL_OUT   = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    HOLD_NONE  = 2'b00,
    HOLD_TIME  = 2'b01,
    HOLD_EVENT = 2'b10
  } hold_t;

endpackage

// ### include/cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cmp_if;
  logic main_q;
  logic hi_q;
  logic lo_q;
  modport src (output main_q, output hi_q, output lo_q);
  modport dst (input main_q, input hi_q, input lo_q);
endinterface
`default_nettype wire

// ### verilog/cmp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_sync
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // Raw comparators
  input  wire logic main_in,
  input  wire logic hi_in,
  input  wire logic lo_in,
  // Synchronised
  cmp_if.src        sync
);

  logic [2:0] meta_q;
  logic [2:0] stab_q;

  // ****************************************************************
  // Two-stage synchroniser; first stage read only by second
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      meta_q <= 3'h0;
      stab_q <= 3'h0;
    end
    else
    begin
      meta_q <= {lo_in, hi_in, main_in};
      stab_q <= meta_q;
    end
  end

  assign sync.main_q = stab_q[0];
  assign sync.hi_q   = stab_q[1];
  assign sync.lo_q   = stab_q[2];

endmodule
`default_nettype wire

// ### verilog/trigger_qualifier.sv
// Contract
// RL1: Trigger only on the slope selected, one slope setting kept per source.
// RL2: After each trigger, suppress triggers for a hold-off by time or events.
// RL3: Time hold-off restarts on each trigger; fire only after delay elapsed.
// RL4: Event hold-off resets on trigger; fire on event after programmed ignored count.
// RL5: An event is an input change meeting the current trigger conditions.
// RL6: Time hold-off supports ten nanoseconds up to twenty seconds.
// RL7: Event hold-off count accepts one up to ten to the ninth.
// RL8: Window mode triggers when signal leaves region between two thresholds.
// RL9: Window is a slope choice; thresholds symmetric about level by window size.
// RL10: High-frequency coupling forced to AC on conflict; only one slope then.
// RL11: Glitch trigger captures pulses narrower or wider than a width limit.
// RL12: Maximum-width glitch fires on selected edge when width below limit.
// RL13: Width measurement restarts on each edge opposite to the trigger edge.
// RL14: Width limits span two and a half nanoseconds to twenty seconds.
// RL15: Exclusion fires on selected edge when width inside or outside range.
// RL16: Programmed level is the source voltage whose crossing forms an event.
// RL17: Trigger output is a one-cycle pulse; durations count clock cycles.
// RL18: Comparator inputs pass a two-stage synchroniser before edge detection.
`timescale 1ns/1ps
`default_nettype none
module trigger_qualifier
(
  // Clock and reset
  input  wire logic                               clk_in,
  input  wire logic                               reset_in,
  // Comparators, one set per source
  input  wire logic [trig_pkg::NSRC-1:0]          level_cmp_in,
  input  wire logic [trig_pkg::NSRC-1:0]          win_hi_cmp_in,
  input  wire logic [trig_pkg::NSRC-1:0]          win_lo_cmp_in,
  // Source selection, per-source slope and coupling, and level and window size shared by all sources
  input  wire logic [trig_pkg::SRC_W-1:0]         source_sel_in,
  input  wire logic [trig_pkg::NSRC*2-1:0]        slope_cfg_in,
  input  wire logic [trig_pkg::NSRC*3-1:0]        coupling_cfg_in,
  input  wire logic [15:0]                        level_cfg_in,
  input  wire logic [15:0]                        window_size_in,
  // Mode and limits
  input  wire trig_pkg::mode_t                    mode_in,
  input  wire trig_pkg::hold_t                    hold_mode_in,
  input  wire trig_pkg::time_t                    hold_time_in,
  input  wire trig_pkg::count_t                   hold_events_in,
  input  wire trig_pkg::time_t                    width_lo_in,
  input  wire trig_pkg::time_t                    width_hi_in,
  // Threshold and coupling outputs to the front end
  output logic [15:0]                             level_out,
  output logic [15:0]                             win_hi_level_out,
  output logic [15:0]                             win_lo_level_out,
  output trig_pkg::coupling_t                     coupling_out,
  output logic                                    coupling_forced_out,
  // Trigger
  output logic                                    trigger_out,
  output logic                                    holdoff_busy_out
);

  cmp_if cmp ();
  logic [2:0] sel_cmp;
  logic       prev_main_q;
  logic       prev_hi_q;
  logic       prev_lo_q;
  logic       rise;
  logic       fall;
  logic       leave_win;
  trig_pkg::slope_t    slope_raw;
  trig_pkg::slope_t    slope;
  trig_pkg::coupling_t cpl_raw;
  logic       win_mode;
  logic       edge_sel;
  logic       edge_opp;
  logic       width_ok;
  logic       candidate;
  logic       fire;
  logic       in_hold_q;
  trig_pkg::time_t  tcount_q;
  trig_pkg::count_t ecount_q;
  trig_pkg::time_t  width_q;
  logic [2:0] src_idx;
  logic [15:0] half_win;

  // ****************************************************************
  // Source select and synchronisation
  // ****************************************************************
  assign src_idx = (source_sel_in < 3'(trig_pkg::NSRC)) ? source_sel_in : 3'h0;

  cmp_sync u_sync
  (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .main_in  (level_cmp_in[src_idx]),  // see RL16
    .hi_in    (win_hi_cmp_in[src_idx]),
    .lo_in    (win_lo_cmp_in[src_idx]),
    .sync     (cmp.src)                  // see RL18
  );

  assign slope_raw = trig_pkg::slope_t'(slope_cfg_in[src_idx*2 +: 2]);  // see RL1
  assign cpl_raw   = trig_pkg::coupling_t'(coupling_cfg_in[src_idx*3 +: 3]);

  // ****************************************************************
  // Coupling override
  // ****************************************************************
  // HF path supports edge mode and a single slope only
  always_comb
  begin
    coupling_forced_out = 1'b0;
    coupling_out        = cpl_raw;
    slope               = slope_raw;
    if (cpl_raw == trig_pkg::CPL_HF)
    begin
      if (mode_in != trig_pkg::MODE_EDGE || slope_raw == trig_pkg::SLOPE_WINDOW)
      begin
        coupling_out        = trig_pkg::CPL_AC;  // see RL10
        coupling_forced_out = 1'b1;
      end
      else
      begin
        slope = trig_pkg::SLOPE_POS;  // see RL10
      end
    end
  end

  // ****************************************************************
  // Window thresholds
  // ****************************************************************
  assign half_win         = window_size_in >> 1;
  assign level_out        = level_cfg_in;  // see RL16
  assign win_hi_level_out = level_cfg_in + half_win;  // see RL9
  assign win_lo_level_out = level_cfg_in - half_win;  // see RL9

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prev_main_q <= 1'b0;
      prev_hi_q   <= 1'b0;
      prev_lo_q   <= 1'b0;  // Matches the cleared synchroniser: no false leave
    end
    else
    begin
      prev_main_q <= cmp.main_q;
      prev_hi_q   <= cmp.hi_q;
      prev_lo_q   <= cmp.lo_q;
    end
  end

  assign rise      = cmp.main_q & ~prev_main_q;
  assign fall      = ~cmp.main_q & prev_main_q;
  // Hi comparator above upper, lo comparator above lower
  assign leave_win = (cmp.hi_q & ~prev_hi_q) | (~cmp.lo_q & prev_lo_q);  // see RL8
  assign win_mode  = (slope == trig_pkg::SLOPE_WINDOW) && (mode_in == trig_pkg::MODE_EDGE);
  assign edge_sel  = (slope == trig_pkg::SLOPE_NEG) ? fall : rise;  // see RL1
  assign edge_opp  = (slope == trig_pkg::SLOPE_NEG) ? rise : fall;

  // ****************************************************************
  // Pulse width measurement
  // ****************************************************************
  // Saturates instead of wrapping, so very long pulses stay long
  // Starts full: no pulse start has been seen after reset
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      width_q <= '1;
    else if (edge_opp)
      width_q <= trig_pkg::TW'(1);  // see RL13
    else if (width_q != '1)
      width_q <= width_q + trig_pkg::TW'(1);  // see RL14
  end

  always_comb
  begin
    case (mode_in)
      trig_pkg::MODE_GLITCH_MAX: width_ok = width_q < width_hi_in;  // see RL12
      trig_pkg::MODE_GLITCH_MIN: width_ok = width_q > width_lo_in;  // see RL11
      trig_pkg::MODE_EXCL_IN:
        width_ok = (width_q >= width_lo_in) && (width_q <= width_hi_in);  // see RL15
      trig_pkg::MODE_EXCL_OUT:
        width_ok = (width_q < width_lo_in) || (width_q > width_hi_in);  // see RL15
      default:                   width_ok = 1'b1;
    endcase
  end

  assign candidate = win_mode ? leave_win : (edge_sel & width_ok);  // see RL5

  // ****************************************************************
  // Hold-off
  // ****************************************************************
  always_comb
  begin
    case (hold_mode_in)
      trig_pkg::HOLD_TIME:  fire = candidate && (!in_hold_q || tcount_q >= hold_time_in);  // see RL3
      trig_pkg::HOLD_EVENT: fire = candidate && (!in_hold_q || ecount_q >= hold_events_in);  // see RL4
      default:              fire = candidate;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      in_hold_q <= 1'b0;
    else if (fire)  // Any trigger, so a hold-off chosen later counts from it
      in_hold_q <= 1'b1;  // see RL2
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      tcount_q <= '0;
    else if (fire)
      tcount_q <= trig_pkg::TW'(1);  // see RL3
    else if (tcount_q != '1)
      tcount_q <= tcount_q + trig_pkg::TW'(1);  // see RL6
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      ecount_q <= '0;
    else if (fire)
      ecount_q <= '0;  // see RL4
    else if (candidate && ecount_q != '1)
      ecount_q <= ecount_q + trig_pkg::EW'(1);  // see RL7
  end

  assign holdoff_busy_out = in_hold_q &&
    ((hold_mode_in == trig_pkg::HOLD_TIME  && tcount_q < hold_time_in) ||
     (hold_mode_in == trig_pkg::HOLD_EVENT && ecount_q < hold_events_in));

  // ****************************************************************
  // Trigger output
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      trigger_out <= 1'b0;
    else
      trigger_out <= fire;  // see RL17
  end

endmodule
`default_nettype wire

// ### tb/trig_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Checker on the qualifier ports
// ************************************
module trig_asserts
(
  // Clock, reset, level comparators and settings
  input wire logic                        clk_in,
  input wire logic                        reset_in,
  input wire logic [trig_pkg::NSRC-1:0]   level_cmp_in,
  input wire logic [trig_pkg::SRC_W-1:0]  source_sel_in,
  input wire logic [trig_pkg::NSRC*2-1:0] slope_cfg_in,
  input wire logic [trig_pkg::NSRC*3-1:0] coupling_cfg_in,
  input wire logic [15:0]                 level_cfg_in,
  input wire logic [15:0]                 window_size_in,
  input wire trig_pkg::mode_t             mode_in,
  input wire trig_pkg::hold_t             hold_mode_in,
  input wire trig_pkg::time_t             hold_time_in,
  // Design outputs
  input wire logic [15:0]                 level_out,
  input wire logic [15:0]                 win_hi_level_out,
  input wire logic [15:0]                 win_lo_level_out,
  input wire trig_pkg::coupling_t         coupling_out,
  input wire logic                        coupling_forced_out,
  input wire logic                        trigger_out,
  input wire logic                        holdoff_busy_out
);
  logic [2:0]  s;
  logic [1:0]  slope;
  logic [2:0]  cpl;
  logic [1:0]  eff;
  logic        clash;
  logic        hit;
  logic        cmp_q;
  logic [31:0] gap_q;
  assign s = (source_sel_in > 3'h4) ? 3'h0 : source_sel_in;
  assign slope = slope_cfg_in[s*2 +: 2];
  assign cpl = coupling_cfg_in[s*3 +: 3];
  assign clash = cpl == trig_pkg::CPL_HF &&
                 (mode_in != trig_pkg::MODE_EDGE || slope == trig_pkg::SLOPE_WINDOW);
  // HF coupling offers one slope only
  assign eff = (cpl == trig_pkg::CPL_HF && !clash) ? 2'(trig_pkg::SLOPE_POS) : slope;
  assign hit = (eff == trig_pkg::SLOPE_NEG) ? cmp_q & !level_cmp_in[s] : !cmp_q & level_cmp_in[s];
  always_ff @(posedge clk_in)
    cmp_q <= level_cmp_in[s];
  // Saturates so that the first trigger after reset is never judged too early
  always_ff @(posedge clk_in)
    if (reset_in)
      gap_q <= '1;
    else if (trigger_out)
      gap_q <= 32'h1;
    else if (gap_q != '1)
      gap_q <= gap_q + 32'h1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_quiet;
    !trigger_out [*2];
  endsequence
  property p_edge;
    trigger_out && mode_in == trig_pkg::MODE_EDGE && eff != trig_pkg::SLOPE_WINDOW &&
      hold_mode_in == trig_pkg::HOLD_NONE |-> $past(hit, 3) || $past(hit, 4);
  endproperty
  property p_gap;
    trigger_out && hold_mode_in == trig_pkg::HOLD_TIME |-> gap_q >= 32'(hold_time_in);
  endproperty
  property p_pulse;
    trigger_out && hold_mode_in == trig_pkg::HOLD_TIME && hold_time_in > 30'h2 |=> s_quiet;
  endproperty
  property p_busy;
    trigger_out && hold_mode_in == trig_pkg::HOLD_TIME && hold_time_in > 30'h2 |-> holdoff_busy_out;
  endproperty
  property p_lvl;
    level_out == level_cfg_in;
  endproperty
  property p_win;
    win_hi_level_out == level_cfg_in + (window_size_in >> 1) &&
      win_lo_level_out == level_cfg_in - (window_size_in >> 1);
  endproperty
  property p_force;
    clash |-> coupling_out == trig_pkg::CPL_AC && coupling_forced_out;
  endproperty
  property p_keep;
    !clash |-> coupling_out == cpl && !coupling_forced_out;
  endproperty
  property p_rst;
    disable iff (1'b0) reset_in |=> !trigger_out;
  endproperty
  a_edge: assert property (p_edge) else $error("trigger without selected edge");
  a_gap: assert property (p_gap) else $error("trigger inside time hold-off");
  a_pulse: assert property (p_pulse) else $error("trigger pulse too long");
  a_busy: assert property (p_busy) else $error("hold-off not busy after trigger");
  a_lvl: assert property (p_lvl) else $error("level output wrong");
  a_win: assert property (p_win) else $error("window levels wrong");
  a_force: assert property (p_force) else $error("coupling not forced");
  a_keep: assert property (p_keep) else $error("coupling changed");
  a_rst: assert property (p_rst) else $error("trigger during reset");
endmodule
`default_nettype wire

// ### tb/front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Comparators of the analog front end
// ************************************
module front_end_model
(
  // Source voltages and thresholds
  input  wire logic [trig_pkg::NSRC*16-1:0] volt_in,
  input  wire logic [15:0]                  level_in,
  input  wire logic [15:0]                  hi_in,
  input  wire logic [15:0]                  lo_in,
  // Comparator decisions
  output logic      [trig_pkg::NSRC-1:0]    level_cmp_out,
  output logic      [trig_pkg::NSRC-1:0]    hi_cmp_out,
  output logic      [trig_pkg::NSRC-1:0]    lo_cmp_out
);
  always_comb
    for (int i = 0; i < trig_pkg::NSRC; i++)
    begin
      level_cmp_out[i] = volt_in[i*16 +: 16] > level_in;
      hi_cmp_out[i]    = volt_in[i*16 +: 16] > hi_in;
      lo_cmp_out[i]    = volt_in[i*16 +: 16] > lo_in;
    end
endmodule
`default_nettype wire

// ### tb/trigger_qualifier_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
// ************************************
// Bench
// ************************************
module trigger_qualifier_test;
  localparam logic [15:0] HI = 16'hf000, MID = 16'h8000, LO = 16'h1000;
  logic                          clk_in = 1'b0;
  logic                          reset_in = 1'b1;
  logic [trig_pkg::NSRC*16-1:0]  volt = '0;
  logic [trig_pkg::NSRC-1:0]     level_cmp_in, win_hi_cmp_in, win_lo_cmp_in;
  logic [2:0]                    source_sel_in = 3'h0;
  logic [9:0]                    slope_cfg_in = 10'h004;
  logic [14:0]                   coupling_cfg_in = '0;
  logic [15:0]                   level_cfg_in = MID, window_size_in = 16'h1000;
  trig_pkg::mode_t               mode_in = trig_pkg::MODE_EDGE;
  trig_pkg::hold_t               hold_mode_in = trig_pkg::HOLD_NONE;
  trig_pkg::time_t               hold_time_in = 30'h14, width_lo_in = 30'h6, width_hi_in = 30'hc;
  trig_pkg::count_t              hold_events_in = 30'h2;
  logic [15:0]                   level_out, win_hi_level_out, win_lo_level_out;
  trig_pkg::coupling_t           coupling_out;
  logic                          coupling_forced_out, trigger_out, holdoff_busy_out;
  int                            num_errors = 0, num_checks = 0, trigs = 0, cycles = 0;
  int                            wexp [4] = '{2, 2, 1, 2};
  int                            wlen [3] = '{3, 9, 16};
  trig_pkg::mode_t               wmode [4] = '{trig_pkg::MODE_GLITCH_MAX, trig_pkg::MODE_GLITCH_MIN,
                                               trig_pkg::MODE_EXCL_IN, trig_pkg::MODE_EXCL_OUT};
  trigger_qualifier trigger_qualifier_inst (.clk_in, .reset_in, .level_cmp_in, .win_hi_cmp_in,
    .win_lo_cmp_in, .source_sel_in, .slope_cfg_in, .coupling_cfg_in, .level_cfg_in,
    .window_size_in, .mode_in, .hold_mode_in, .hold_time_in, .hold_events_in, .width_lo_in,
    .width_hi_in, .level_out, .win_hi_level_out, .win_lo_level_out, .coupling_out,
    .coupling_forced_out, .trigger_out, .holdoff_busy_out);
  front_end_model front_end_model_inst (.volt_in(volt), .level_in(level_out),
    .hi_in(win_hi_level_out), .lo_in(win_lo_level_out), .level_cmp_out(level_cmp_in),
    .hi_cmp_out(win_hi_cmp_in), .lo_cmp_out(win_lo_cmp_in));
  always #10 clk_in = ~clk_in;
  // Counts trigger pulses; the run is far shorter than the ceiling
  always @(posedge clk_in)
  begin
    cycles++;
    if (trigger_out === 1'b1)
      trigs++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic set_v(input int src, input logic [15:0] v, input int n);
    @(negedge clk_in);
    volt[src*16 +: 16] = v;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic expect_n(input string what, input int n);
    repeat (8) @(negedge clk_in);
    `CHK(what, n, trigs)
    trigs = 0;
  endtask
  task automatic pulse_chk(input int src, input int nr, input int nf);
    set_v(src, HI, 10);
    expect_n("rise", nr);
    set_v(src, LO, 10);
    expect_n("fall", nf);
  endtask
  task automatic burst(input string what, input int n, input int h, input int e);
    repeat (n)
    begin
      set_v(0, HI, h);
      set_v(0, LO, h);
    end
    expect_n(what, e);
  endtask
  initial
  begin
    repeat (8) @(negedge clk_in);
    reset_in = 1'b0;
    expect_n("idle", 0);
    pulse_chk(0, 1, 0);
    source_sel_in = 3'h1;
    pulse_chk(1, 0, 1);
    source_sel_in = 3'h0;
    pulse_chk(0, 1, 0);
    burst("no hold", 5, 3, 5);
    hold_mode_in = trig_pkg::HOLD_TIME;
    burst("time hold", 12, 3, 3);
    hold_mode_in = trig_pkg::HOLD_EVENT;
    burst("event hold", 9, 3, 3);
    hold_events_in = 30'h1;
    burst("event one", 4, 3, 2);
    hold_mode_in = trig_pkg::HOLD_NONE;
    source_sel_in = 3'h2;
    slope_cfg_in[5:4] = trig_pkg::SLOPE_WINDOW;
    expect_n("window setup", 0);
    foreach (wexp[i])
    begin
      set_v(2, (i == 1) ? HI : (i == 3) ? LO : MID, 10);
      expect_n("window", i % 2);
    end
    source_sel_in = 3'h0;
    set_v(0, HI, 20);
    expect_n("source edge", 1);
    foreach (wmode[m])
    begin
      mode_in = wmode[m];
      expect_n("mode setup", 0);
      foreach (wlen[k])
      begin
        set_v(0, LO, wlen[k]);
        set_v(0, HI, 20);
      end
      expect_n("width", wexp[m]);
    end
    mode_in = trig_pkg::MODE_EDGE;
    for (int c = 0; c < 5; c++)
    begin
      @(negedge clk_in);
      coupling_cfg_in[2:0] = 3'(c);
      #1 `CHK("coupling", 3'(c), coupling_out)
      `CHK("not forced", 1'b0, coupling_forced_out)
    end
    @(negedge clk_in);
    mode_in = trig_pkg::MODE_GLITCH_MAX;
    #1 `CHK("forced ac", trig_pkg::CPL_AC, coupling_out)
    `CHK("forced", 1'b1, coupling_forced_out)
    @(negedge clk_in);
    mode_in = trig_pkg::MODE_EDGE;
    slope_cfg_in[1:0] = trig_pkg::SLOPE_NEG;
    set_v(0, LO, 10);
    expect_n("hf fall", 0);
    set_v(0, HI, 10);
    expect_n("hf rise", 1);
    coupling_cfg_in = '0;
    slope_cfg_in[1:0] = trig_pkg::SLOPE_POS;
    set_v(0, LO, 10);
    expect_n("settle", 0);
    set_v(0, HI, 1);
    @(negedge clk_in) reset_in = 1'b1;
    set_v(0, LO, 6);
    @(negedge clk_in) reset_in = 1'b0;
    expect_n("reset", 0);
    pulse_chk(0, 1, 0);
    end_of_test();
  end
endmodule
bind trigger_qualifier trig_asserts trig_asserts_inst (.clk_in, .reset_in, .level_cmp_in,
  .source_sel_in, .slope_cfg_in, .coupling_cfg_in, .level_cfg_in, .window_size_in, .mode_in,
  .hold_mode_in, .hold_time_in, .level_out, .win_hi_level_out, .win_lo_level_out,
  .coupling_out, .coupling_forced_out, .trigger_out, .holdoff_busy_out);
`undef CHK
`default_nettype wire
